// *** bdcm_pkg.sv ***
// bdcm_pkg: shared constants for the block configuration memory.
// assumes: included before the interface and the modules.
package bdcm_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int DEPTH  = 8;
	// ---------------------------------------------------------------
	// address map
	// ---------------------------------------------------------------
	// cell 7: read returns status, write pulses function enables
	localparam logic [ADDR_W-1:0] STAT_ADDR = 7'h07;
	// cells 0..5 read-write, cell 6 read-only
	localparam logic [ADDR_W-1:0] RO_ADDR   = 7'h06;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	// cycles from taken request to the access_done pulse
	localparam logic [3:0] LAT_CYC = 4'h3;
	typedef enum logic [1:0]
	{
		BDCM_IDLE = 2'b00,
		BDCM_BUSY = 2'b01,
		BDCM_DONE = 2'b10
	} bdcm_state_t;
endpackage

// *** bdcm_cell_if.sv ***
// bdcm_cell_if: write path between the port controller and the cell array.
// assumes: both ends on core_clk_i.
`timescale 1ns/1ps
interface bdcm_cell_if;
	logic                      wr_en;
	logic [bdcm_pkg::ADDR_W-1:0] wr_addr;
	logic [bdcm_pkg::DATA_W-1:0] wr_data;
	logic [bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1:0] cells;
	modport ctrl (output wr_en, output wr_addr, output wr_data, input cells);
	modport array (input wr_en, input wr_addr, input wr_data, output cells);
endinterface

// *** bdcm_cell_array.sv ***
// bdcm_cell_array: flip-flop storage of the configuration cells.
// assumes: one writer at a time, initial image given by the load inputs.
`timescale 1ns/1ps
module bdcm_cell_array
(
	input  wire logic                                          core_clk_i,
	input  wire logic                                          load_i,
	input  wire logic [bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1:0]   load_image_i,
	bdcm_cell_if.array                                          cif
);
	logic [bdcm_pkg::DATA_W-1:0] mem_q [bdcm_pkg::DEPTH];
	logic [bdcm_pkg::DATA_W-1:0] mem_d [bdcm_pkg::DEPTH];

	genvar g;
	generate
		for (g = 0; g < bdcm_pkg::DEPTH; g++)
		begin : g_cell
			always_comb
			begin
				mem_d[g] = mem_q[g];
				if (load_i)
					mem_d[g] = load_image_i[g*bdcm_pkg::DATA_W +: bdcm_pkg::DATA_W];
				else if (cif.wr_en && cif.wr_addr == bdcm_pkg::ADDR_W'(g))
					mem_d[g] = cif.wr_data;
			end
			always_ff @(posedge core_clk_i)
				mem_q[g] <= mem_d[g];
			assign cif.cells[g*bdcm_pkg::DATA_W +: bdcm_pkg::DATA_W] = mem_q[g];
		end
	endgenerate
endmodule // bdcm_cell_array

// *** bdcm_config_mem.sv ***
// bdcm_config_mem: configuration memory with fabric port and config-port write.
// assumes: fabric inputs on core_clk_i; srst_i models the bitstream load.
`timescale 1ns/1ps
// What this block does
// - addressable cell memory reachable from fabric, per-cell read/write access
// - every cell loads its bitstream value at configuration
// - config access port can also rewrite cells after initialization
// - stored cell values drive the functional logic through config_bits_o, registered one cycle behind the cells
// - map holds read-only status and write-only enable locations
// - shared address reads status, write only fires function enables
// - inputs registered on rising edge; enable one cycle with address
// - access_done pulses one cycle; read data valid only then
// - write data captured at enable cycle, stored before access_done
module bdcm_config_mem
(
	input  wire logic                                        core_clk_i,
	input  wire logic                                        srst_i,
	input  wire logic [bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1:0] boot_image_i,
	input  wire logic                                        access_enable_i,
	input  wire logic                                        write_select_i,
	input  wire logic [bdcm_pkg::ADDR_W-1:0]                 cell_address_i,
	input  wire logic [bdcm_pkg::DATA_W-1:0]                 write_data_bus_i,
	input  wire logic                                        cfg_wr_en_i,
	input  wire logic [bdcm_pkg::ADDR_W-1:0]                 cfg_wr_addr_i,
	input  wire logic [bdcm_pkg::DATA_W-1:0]                 cfg_wr_data_i,
	input  wire logic [bdcm_pkg::DATA_W-1:0]                 status_i,
	output logic      [bdcm_pkg::DATA_W-1:0]                 read_data_o,
	output logic                                             access_done_o,
	output logic      [bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1:0] config_bits_o,
	output logic      [bdcm_pkg::DATA_W-1:0]                 func_strobe_o
);
	bdcm_cell_if cif ();

	bdcm_cell_array u_array
	(
		.core_clk_i   (core_clk_i),
		.load_i       (srst_i),
		.load_image_i (boot_image_i),
		.cif          (cif)
	);

	// ---------------------------------------------------------------
	// access sequencer
	// ---------------------------------------------------------------
	bdcm_pkg::bdcm_state_t        st_q, st_d;
	logic [3:0]                   cnt_q, cnt_d;
	logic                         we_q, we_d;
	logic [bdcm_pkg::ADDR_W-1:0]  addr_q, addr_d;
	logic [bdcm_pkg::DATA_W-1:0]  wdat_q, wdat_d;
	logic [bdcm_pkg::DATA_W-1:0]  rdat_q, rdat_d;
	logic                         done_q, done_d;
	logic [bdcm_pkg::DATA_W-1:0]  strb_q, strb_d;
	logic [bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1:0] cfg_q, cfg_d;
	logic                         port_wr;
	logic                         take;
	logic                         in_map;
	logic [bdcm_pkg::DATA_W-1:0]  rd_mux;

	// next access may be taken in the very cycle access_done shows
	assign take = access_enable_i && (st_q == bdcm_pkg::BDCM_IDLE || done_q);
	assign in_map = addr_q < bdcm_pkg::ADDR_W'(bdcm_pkg::DEPTH - 1);
	assign port_wr = st_q == bdcm_pkg::BDCM_BUSY && cnt_q == 4'h1 && we_q && in_map
		&& addr_q != bdcm_pkg::RO_ADDR;

	always_comb
	begin
		rd_mux = '0;
		if (addr_q == bdcm_pkg::STAT_ADDR)
			rd_mux = status_i;
		else if (addr_q <= bdcm_pkg::RO_ADDR)
			rd_mux = cif.cells[addr_q[2:0]*bdcm_pkg::DATA_W +: bdcm_pkg::DATA_W];
	end

	// config port wins the cell array; a colliding fabric write is retried next cycle
	always_comb
	begin
		cif.wr_en   = cfg_wr_en_i || port_wr;
		cif.wr_addr = cfg_wr_en_i ? cfg_wr_addr_i : addr_q;
		cif.wr_data = cfg_wr_en_i ? cfg_wr_data_i : wdat_q;
	end

	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		we_d   = we_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		done_d = 1'b0;
		strb_d = '0;
		cfg_d  = cif.cells;
		case (st_q)
			bdcm_pkg::BDCM_IDLE,
			bdcm_pkg::BDCM_DONE:
			begin
				st_d = bdcm_pkg::BDCM_IDLE;
				if (take)
				begin
					st_d   = bdcm_pkg::BDCM_BUSY;
					cnt_d  = bdcm_pkg::LAT_CYC;
					we_d   = write_select_i;
					addr_d = cell_address_i;
					wdat_d = write_data_bus_i;
				end
			end
			bdcm_pkg::BDCM_BUSY:
			begin
				if (cnt_q == 4'h1 && cfg_wr_en_i && port_wr)
					cnt_d = cnt_q;
				else if (cnt_q == 4'h1)
				begin
					st_d   = bdcm_pkg::BDCM_DONE;
					done_d = 1'b1;
					rdat_d = rd_mux;
					if (we_q && addr_q == bdcm_pkg::STAT_ADDR)
						strb_d = wdat_q;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			default:
				st_d = bdcm_pkg::BDCM_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			st_q   <= bdcm_pkg::BDCM_IDLE;
			cnt_q  <= 4'h0;
			we_q   <= 1'b0;
			addr_q <= '0;
			wdat_q <= '0;
			rdat_q <= '0;
			done_q <= 1'b0;
			strb_q <= '0;
			cfg_q  <= '0;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			we_q   <= we_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			done_q <= done_d;
			strb_q <= strb_d;
			cfg_q  <= cfg_d;
		end
	end

	assign read_data_o   = rdat_q;
	assign access_done_o = done_q;
	assign func_strobe_o = strb_q;
	assign config_bits_o = cfg_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_done_one
		;
		@(posedge core_clk_i) disable iff (srst_i)
		access_done_o |=> !access_done_o;
	endproperty
	a_done_one : assert property (p_done_one) else $error("done held");

	property p_take_done
		;
		@(posedge core_clk_i) disable iff (srst_i)
		(take && !cfg_wr_en_i) |-> ##[1:8] access_done_o;
	endproperty
	a_take_done : assert property (p_take_done) else $error("no done");

	property p_ignore
		;
		@(posedge core_clk_i) disable iff (srst_i)
		(st_q == bdcm_pkg::BDCM_BUSY && access_enable_i) |=> $stable(addr_q) && $stable(we_q)
			&& $stable(wdat_q);
	endproperty
	a_ignore : assert property (p_ignore) else $error("busy enable taken");

	property p_ro
		;
		@(posedge core_clk_i) disable iff (srst_i)
		// top two cells (read-only, status) move only by load or config port
		!srst_i && !cfg_wr_en_i |=>
			$stable(cif.cells[bdcm_pkg::DATA_W*bdcm_pkg::DEPTH-1 -: 2*bdcm_pkg::DATA_W]);
	endproperty
	a_ro : assert property (p_ro) else $error("write to read-only");

	property p_strobe
		;
		@(posedge core_clk_i) disable iff (srst_i)
		(func_strobe_o != '0) |-> access_done_o && $past(we_q)
			&& $past(addr_q) == bdcm_pkg::STAT_ADDR;
	endproperty
	a_strobe : assert property (p_strobe) else $error("stray strobe");

	property p_wr_before
		;
		@(posedge core_clk_i) disable iff (srst_i)
		port_wr && !cfg_wr_en_i |=> access_done_o;
	endproperty
	a_wr_before : assert property (p_wr_before) else $error("write late");

	property p_cfg_wr
		;
		@(posedge core_clk_i) disable iff (srst_i)
		cfg_wr_en_i && cfg_wr_addr_i < bdcm_pkg::ADDR_W'(bdcm_pkg::DEPTH) |=> ##1
			config_bits_o[$past(cfg_wr_addr_i[2:0],2)*bdcm_pkg::DATA_W +: bdcm_pkg::DATA_W]
			== $past(cfg_wr_data_i,2);
	endproperty
	a_cfg_wr : assert property (p_cfg_wr) else $error("cfg write lost");

	property p_load
		;
		@(posedge core_clk_i)
		srst_i ##1 !srst_i && !cfg_wr_en_i |-> ##1 config_bits_o == $past(boot_image_i,2);
	endproperty
	a_load : assert property (p_load) else $error("load lost");
endmodule // bdcm_config_mem

// *** bdcm_fabric_model.sv ***
// bdcm_fabric_model: fabric user logic on the access port.
// assumes: one caller of access() at a time.
`timescale 1ns/1ps
module bdcm_fabric_model
(
	input  wire logic                        core_clk_i,
	input  wire logic                        access_done_i,
	input  wire logic [bdcm_pkg::DATA_W-1:0] read_data_i,
	input  wire logic [bdcm_pkg::DATA_W-1:0] func_strobe_i,
	output logic                             access_enable_o,
	output logic                             write_select_o,
	output logic      [bdcm_pkg::ADDR_W-1:0] cell_address_o,
	output logic      [bdcm_pkg::DATA_W-1:0] write_data_bus_o
);
	initial
	begin
		access_enable_o  = 1'b0;
		write_select_o   = 1'b0;
		cell_address_o   = '0;
		write_data_bus_o = '0;
	end
	// stray repeats the enable while busy, with other data
	task automatic access(input logic we, input logic [bdcm_pkg::ADDR_W-1:0] a,
		input logic [bdcm_pkg::DATA_W-1:0] d, input bit stray,
		output logic [bdcm_pkg::DATA_W-1:0] rd, output logic [bdcm_pkg::DATA_W-1:0] stb,
		output int lat);
		int n;
		lat = -1;
		@(posedge core_clk_i);
		access_enable_o  <= 1'b1;
		write_select_o   <= we;
		cell_address_o   <= a;
		write_data_bus_o <= d;
		for (n = 0; n < 20 && lat < 0; n++)
		begin
			@(posedge core_clk_i);
			access_enable_o <= stray && n == 0;
			if (stray && n == 0)
				write_data_bus_o <= ~d;
			#1;
			if (access_done_i === 1'b1)
			begin
				// edges counted from the taking edge
				lat = n;
				rd  = read_data_i;
				stb = func_strobe_i;
			end
		end
		// released lines show inverted values, never the old request
		@(posedge core_clk_i);
		write_select_o   <= ~we;
		cell_address_o   <= ~a;
		write_data_bus_o <= ~d;
		#1;
		if (access_done_i !== 1'b0 && lat > 0)
			lat = 0;
	endtask
endmodule // bdcm_fabric_model

// *** bdcm_config_mem_tb.sv ***
// bdcm_config_mem_tb: random fabric and config traffic against a cell model.
// assumes: latency of 3 cycles from the taking edge.
`timescale 1ns/1ps
module bdcm_config_mem_tb;
	localparam int DW = bdcm_pkg::DATA_W;
	localparam int NC = bdcm_pkg::DEPTH;
	logic                        core_clk_i = 1'b0;
	logic                        srst_i     = 1'b1;
	logic                        cfg_en     = 1'b0;
	logic                        en, we, done, w;
	logic [DW*NC-1:0]            image, bits;
	logic [bdcm_pkg::ADDR_W-1:0] addr, ca, a;
	logic [DW-1:0]               wdata, cd, status, rdata, fstb, rd, stb, d, er;
	logic [DW-1:0]               mem [NC];
	int                          errors = 0, compares = 0, seed = 48656, lat, i, k, el;

	always #2.5 core_clk_i = ~core_clk_i;

	bdcm_config_mem dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .boot_image_i(image),
		.access_enable_i(en), .write_select_i(we), .cell_address_i(addr),
		.write_data_bus_i(wdata), .cfg_wr_en_i(cfg_en), .cfg_wr_addr_i(ca),
		.cfg_wr_data_i(cd), .status_i(status), .read_data_o(rdata),
		.access_done_o(done), .config_bits_o(bits), .func_strobe_o(fstb));

	bdcm_fabric_model u_fab (.core_clk_i(core_clk_i), .access_done_i(done),
		.read_data_i(rdata), .func_strobe_i(fstb), .access_enable_o(en),
		.write_select_o(we), .cell_address_o(addr), .write_data_bus_o(wdata));

	task automatic check(input logic [DW*NC-1:0] seen, input logic [DW*NC-1:0] exp,
		input string msg);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	function automatic logic [DW*NC-1:0] flat();
		logic [DW*NC-1:0] f;
		for (int j = 0; j < NC; j++)
			f[j*DW +: DW] = mem[j];
		return f;
	endfunction

	task automatic finish_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		image  = {$random(seed), $random(seed), $random(seed), $random(seed)};
		status = '0;
		ca     = '0;
		cd     = '0;
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		for (k = 0; k < NC; k++)
			mem[k] = image[k*DW +: DW];
		repeat (2) @(posedge core_clk_i);
		#1;
		check(bits, flat(), "boot image");
		for (i = 0; i < 80; i++)
		begin
			if (i == 40)
			begin
				// mid-run reload: a fresh image must overwrite rewritten cells
				@(posedge core_clk_i);
				srst_i <= 1'b1;
				image  <= {$random(seed), $random(seed), $random(seed), $random(seed)};
				repeat (3) @(posedge core_clk_i);
				srst_i <= 1'b0;
				for (k = 0; k < NC; k++)
					mem[k] = image[k*DW +: DW];
				repeat (2) @(posedge core_clk_i);
				#1;
				check(bits, flat(), "reload image");
				check(128'({done, fstb}), 128'(0), "outputs after reload");
			end
			a = 7'({$random(seed)} % 10);
			w = 1'($random(seed));
			d = 16'($random(seed));
			@(posedge core_clk_i);
			status <= 16'($random(seed));
			cfg_en <= (i % 7 == 3);
			ca     <= 7'({$random(seed)} % NC);
			cd     <= 16'($random(seed));
			@(posedge core_clk_i);
			cfg_en <= 1'b0;
			if (i % 7 == 3)
				mem[ca] = cd;
			er = (a == 7) ? status : (a < 7) ? mem[a] : '0;
			fork
				u_fab.access(w, a, d, i % 5 == 1, rd, stb, lat);
				// config write in the fabric write step: config port wins, fabric retries
				if (i % 7 == 5)
				begin
					repeat (4) @(posedge core_clk_i);
					cfg_en <= 1'b1;
					@(posedge core_clk_i);
					cfg_en <= 1'b0;
				end
			join
			if (lat < 0)
			begin
				errors++;
				break;
			end
			el = int'(bdcm_pkg::LAT_CYC);
			if (i % 7 == 5 && w && a < 6)
				el++;
			check(128'(lat), 128'(el), "latency or done width");
			if (!w)
				check(128'(rd), 128'(er), "read data");
			if (i % 7 == 5)
				mem[ca] = cd;
			if (w && a < 6)
				mem[a] = d;
			check(128'(stb), 128'((w && a == 7) ? d : '0), "function strobe");
			check(bits, flat(), "cell contents");
		end
		finish_test();
	end
endmodule // bdcm_config_mem_tb
